/* File: aad_alu.sv */
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps

// Function
// - Word magnitude: non-negative passes, negative becomes zero minus input.
// - Either accumulator source for a single destination; dual form writes each accumulator's own magnitude and ORs the zero results.
// - Magnitude clears sign; data wrap only on word most-negative clamp.
// - Accumulator wrap flag follows overflow for its own destination.
// - Sticky flags set with their wrap flag, else hold.
// - Pointer addition writes the sum and leaves all flags.
// - Short-encoded word add never saturates; long one carries a selector.
// - Selector picks saturate or wrap.
// - Half-word add: any halves in, chosen half out, long encoding only.
// - Word add sets zero, sign, carry and data wrap from the result.
// - Add-immediate sign-extends a seven-bit constant, -64 to 63.
// - Add-immediate never saturates.
// - Index add-immediate steps by 2 or 4 only.
// - Only data targets of add-immediate touch flags.
// - Only index add-immediate and long-encoded ops report pairable.
// - Divide init sets qsign, shifts dividend, inserts qsign.
// - Divide iterate adds or subtracts, recomputes qsign, inserts its inverse.
// - Qsign one adds the divisor; zero subtracts it.
// - Qsign is dividend MSB xor divisor half MSB.
// - Divide uses divisor low half only, never writes it.
module aad_alu (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output aad_pkg::aad_flags_t statusFlags
);
    import aad_pkg::*;

    typedef struct packed {
        aad_bus_t busSt;
        logic [31:0] opA;
        logic [31:0] opB;
        logic [39:0] acc0;
        logic [39:0] acc1;
        logic [31:0] result;
        aad_flags_t flags;
        logic pairable;
        logic refused;
        logic [31:0] rdata;
    } aad_state_t;

    aad_state_t st;
    aad_state_t next_st;

    // ==========================================
    // Helpers
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : mergeBytes

    // Returns {clamped, value}; the most negative input cannot be negated
    function automatic logic [40:0] absAcc(input logic [39:0] x);
        if (x == ACC_MIN) return {1'b1, ACC_MAX};
        return {1'b0, x[39] ? 40'h00_0000_0000 - x : x};
    endfunction : absAcc

    function automatic logic [15:0] pickHalf(input logic [31:0] x, input logic hi);
        return hi ? x[31:16] : x[15:0];
    endfunction : pickHalf

    // ==========================================
    // Datapath
    logic exec;
    aad_op_t op;
    logic [31:0] addA;
    logic [31:0] addB;
    logic addSat;
    logic [31:0] addSum;
    logic addZero;
    logic addSign;
    logic addCarry;
    logic addOvf;
    logic [31:0] divOut;
    logic divQs;
    logic [40:0] absA0;
    logic [40:0] absA1;
    logic [31:0] immExt;

    assign exec = (st.busSt == BUS_ACK) && write && (address == OFS_CTRL);
    assign op = aad_op_t'(writedata[3:0]);
    assign immExt = {{(32-IMM_W){writedata[CTL_IMM_LSB+IMM_W-1]}},
                     writedata[CTL_IMM_LSB +: IMM_W]};

    always_comb begin
        addA = st.opA;
        addB = st.opB;
        addSat = 1'b0;
        if (op == OP_ADD_H) begin
            // Halves ride in the top lane so carry and overflow are the 16-bit ones
            addA = {pickHalf(st.opA, writedata[CTL_AHI]), 16'h0000};
            addB = {pickHalf(st.opB, writedata[CTL_BHI]), 16'h0000};
            addSat = writedata[CTL_SAT];
        end else if (op == OP_ADD_D) begin
            addSat = writedata[CTL_ENC32] && writedata[CTL_SAT];
        end else if (op == OP_IMM_D || op == OP_IMM_P) begin
            addB = immExt;
        end
    end

    aad_adder #(
        .W(32)
    ) uAdd (
        .opA(addA),
        .opB(addB),
        .sat(addSat),
        .sum(addSum),
        .zero(addZero),
        .sign(addSign),
        .carry(addCarry),
        .ovf(addOvf)
    );

    // Divisor high half never reaches the step
    aad_divider uDiv (
        .dividend(st.opA),
        .divisor(st.opB[15:0]),
        .qsIn(st.flags.quotientSign),
        .initStep(op == OP_DIV_INIT),
        .newDividend(divOut),
        .qsOut(divQs)
    );

    assign absA0 = absAcc(writedata[CTL_SRC1] ? st.acc1 : st.acc0);
    assign absA1 = absAcc(writedata[CTL_SRC1] ? st.acc1 : st.acc0);

    // ==========================================
    // Next state
    always_comb begin
        logic [40:0] own0;
        logic [40:0] own1;
        logic dual;
        aad_flags_t f;
        own0 = absAcc(st.acc0);
        own1 = absAcc(st.acc1);
        dual = writedata[CTL_DST0] && writedata[CTL_DST1];
        next_st = st;
        f = st.flags;
        case (st.busSt)
            BUS_IDLE: begin
                if (read || write) begin
                    next_st.busSt = BUS_ACK;
                end
                next_st.rdata = 32'h0000_0000;
                if (address == OFS_CTRL) next_st.rdata = 32'h0000_0000;
                else if (address == OFS_OPA) next_st.rdata = st.opA;
                else if (address == OFS_OPB) next_st.rdata = st.opB;
                else if (address == OFS_ACC0L) next_st.rdata = st.acc0[31:0];
                else if (address == OFS_ACC0H) next_st.rdata = {24'h000000, st.acc0[39:32]};
                else if (address == OFS_ACC1L) next_st.rdata = st.acc1[31:0];
                else if (address == OFS_ACC1H) next_st.rdata = {24'h000000, st.acc1[39:32]};
                else if (address == OFS_RESULT) next_st.rdata = st.result;
                else if (address == OFS_FLAGS) next_st.rdata = {22'h000000, st.flags};
                else if (address == OFS_STATUS) next_st.rdata = {30'h0, st.refused, st.pairable};
            end
            BUS_ACK: begin
                next_st.busSt = BUS_IDLE;
                if (write) begin
                    if (address == OFS_OPA) begin
                        next_st.opA = mergeBytes(st.opA, writedata, byteenable);
                    end else if (address == OFS_OPB) begin
                        next_st.opB = mergeBytes(st.opB, writedata, byteenable);
                    end else if (address == OFS_ACC0L) begin
                        next_st.acc0[31:0] = mergeBytes(st.acc0[31:0], writedata, byteenable);
                    end else if (address == OFS_ACC0H && byteenable[0]) begin
                        next_st.acc0[39:32] = writedata[7:0];
                    end else if (address == OFS_ACC1L) begin
                        next_st.acc1[31:0] = mergeBytes(st.acc1[31:0], writedata, byteenable);
                    end else if (address == OFS_ACC1H && byteenable[0]) begin
                        next_st.acc1[39:32] = writedata[7:0];
                    end else if (address == OFS_FLAGS) begin
                        next_st.flags = aad_flags_t'(writedata[9:0]);
                    end
                end
                if (exec) begin
                    next_st.refused = 1'b0;
                    // Long encodings and the index step may pair; the rest issue alone
                    next_st.pairable = (op == OP_IMM_I) || (op == OP_ABS_D) || (op == OP_ABS_ACC)
                        || (op == OP_ADD_H)
                        || (op == OP_ADD_D && writedata[CTL_ENC32]);
                    // All effects land in next_st together and commit on one edge
                    case (op)
                        OP_ABS_D: begin
                            if (st.opA == WORD_MIN) begin
                                next_st.result = WORD_MAX;
                                f.dataWrap = 1'b1;
                            end else begin
                                next_st.result = st.opA[31] ? 32'h0 - st.opA : st.opA;
                                f.dataWrap = 1'b0;
                            end
                            f.zeroFlag = (next_st.result == 32'h0);
                            f.dataWrapSticky = st.flags.dataWrapSticky | f.dataWrap;
                            f.signFlag = 1'b0;
                        end
                        OP_ABS_ACC: begin
                            f.zeroFlag = 1'b0;
                            if (dual) begin
                                next_st.acc0 = own0[39:0];
                                next_st.acc1 = own1[39:0];
                                f.acc0WrapFlag = own0[40];
                                f.acc1WrapFlag = own1[40];
                                f.acc0WrapSticky = st.flags.acc0WrapSticky | own0[40];
                                f.acc1WrapSticky = st.flags.acc1WrapSticky | own1[40];
                                f.zeroFlag = (own0[39:0] == '0) || (own1[39:0] == '0);
                            end else if (writedata[CTL_DST1]) begin
                                next_st.acc1 = absA1[39:0];
                                f.acc1WrapFlag = absA1[40];
                                f.acc1WrapSticky = st.flags.acc1WrapSticky | absA1[40];
                                f.zeroFlag = (absA1[39:0] == '0);
                            end else begin
                                next_st.acc0 = absA0[39:0];
                                f.acc0WrapFlag = absA0[40];
                                f.acc0WrapSticky = st.flags.acc0WrapSticky | absA0[40];
                                f.zeroFlag = (absA0[39:0] == '0);
                            end
                            f.signFlag = 1'b0;
                            f.dataWrap = 1'b0;
                        end
                        OP_ADD_P, OP_IMM_P: begin
                            next_st.result = addSum;
                        end
                        OP_IMM_I: begin
                            next_st.result = st.opA + (writedata[CTL_STEP4] ? IDX_STEP_WORD
                                : IDX_STEP_HALF);
                        end
                        OP_ADD_D, OP_IMM_D, OP_ADD_H: begin
                            if (op == OP_ADD_H && !writedata[CTL_ENC32]) begin
                                // No short form exists; the command is dropped
                                next_st.refused = 1'b1;
                            end else begin
                                if (op == OP_ADD_H) begin
                                    if (writedata[CTL_DSTHI]) begin
                                        next_st.result[31:16] = addSum[31:16];
                                    end else begin
                                        next_st.result[15:0] = addSum[31:16];
                                    end
                                end else begin
                                    next_st.result = addSum;
                                end
                                f.zeroFlag = addZero;
                                f.signFlag = addSign;
                                f.carryFlag = addCarry;
                                f.dataWrap = addOvf;
                                f.dataWrapSticky = st.flags.dataWrapSticky | addOvf;
                            end
                        end
                        OP_DIV_INIT, OP_DIV_ITER: begin
                            next_st.opA = divOut;
                            next_st.result = divOut;
                            f.quotientSign = divQs;
                        end
                        default: begin
                            next_st.refused = 1'b1;
                        end
                    endcase
                    // Stickies follow only what this op wrote; software-set flags stay put
                    next_st.flags = f;
                end
            end
            default: begin
                next_st.busSt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st <= '{busSt: BUS_IDLE, flags: FLAGS_RST, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // One wait state on every access keeps read data registered
    assign waitrequest = (read || write) && (st.busSt == BUS_IDLE);
    assign readdata = st.rdata;
    assign statusFlags = st.flags;

    // ==========================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    chk_abs_pass: assert property (exec && op == OP_ABS_D && !st.opA[31]
        |=> st.result == $past(st.opA)) else $error("magnitude altered a positive word");
    chk_abs_flags: assert property (exec && op == OP_ABS_D && st.opA == WORD_MIN
        |=> st.flags.dataWrap && !st.flags.signFlag && st.result == WORD_MAX)
        else $error("most negative word not clamped");
    // Neither source can overflow unless it holds the most negative value
    chk_acc_wrap: assert property (exec && op == OP_ABS_ACC
        && st.acc0 != ACC_MIN && st.acc1 != ACC_MIN
        && !st.flags.acc0WrapFlag && !st.flags.acc1WrapFlag
        |=> !st.flags.acc0WrapFlag && !st.flags.acc1WrapFlag) else $error("spurious acc wrap");
    chk_sticky_follow: assert property (exec
        && (op == OP_ABS_D || op == OP_ADD_D || op == OP_IMM_D)
        |=> !st.flags.dataWrap || st.flags.dataWrapSticky) else $error("sticky missed");
    chk_sticky_acc0: assert property (exec && op == OP_ABS_ACC
        && (writedata[CTL_DST0] || !writedata[CTL_DST1])
        |=> !st.flags.acc0WrapFlag || st.flags.acc0WrapSticky) else $error("acc sticky missed");
    chk_sticky_hold: assert property (exec && st.flags.dataWrapSticky
        |=> st.flags.dataWrapSticky) else $error("sticky lost");
    chk_sign_clear: assert property (exec && (op == OP_ABS_D || op == OP_ABS_ACC)
        |=> !st.flags.signFlag) else $error("magnitude left sign set");
    chk_ptr_flags: assert property (exec
        && (op == OP_ADD_P || op == OP_IMM_P || op == OP_IMM_I)
        |=> $stable(st.flags)) else $error("pointer op touched flags");
    chk_short_nosat: assert property (exec && op == OP_ADD_D && !writedata[CTL_ENC32]
        |=> st.result == $past(st.opA) + $past(st.opB)) else $error("short add saturated");
    chk_imm_ext: assert property (exec && op == OP_IMM_D
        |=> st.result == $past(st.opA) + $past(immExt)) else $error("immediate add wrong");
    chk_idx_step: assert property (exec && op == OP_IMM_I && writedata[CTL_STEP4]
        |=> st.result == $past(st.opA) + IDX_STEP_WORD) else $error("index step wrong");
    chk_div_init: assert property (exec && op == OP_DIV_INIT
        |=> st.flags.quotientSign == ($past(st.opA[31]) ^ $past(st.opB[15]))
        && st.opA[0] == st.flags.quotientSign) else $error("divide init wrong");
    chk_div_iter: assert property (exec && op == OP_DIV_ITER
        |=> st.opA[0] == !st.flags.quotientSign && $stable(st.opB))
        else $error("divide step wrong");
    chk_bus_answer: assert property ((read || write) && waitrequest
        |=> !waitrequest || !(read || write)) else $error("bus answer late");

    chk_half_refuse: assert property (exec && op == OP_ADD_H && !writedata[CTL_ENC32]
        |=> st.refused && $stable(st.result)) else $error("short half add ran");

    logic dual_c;
    assign dual_c = writedata[CTL_DST0] && writedata[CTL_DST1];

    cov_dual_abs: cover property (exec && op == OP_ABS_ACC && dual_c);
    cov_acc_cross: cover property (exec && op == OP_ABS_ACC && writedata[CTL_SRC1] && !dual_c);
    cov_sat_add: cover property (exec && op == OP_ADD_D && addSat && addOvf);
    cov_div_iter: cover property (exec && op == OP_DIV_ITER && st.flags.quotientSign);
endmodule : aad_alu

/* File: aad_pkg.sv */
package aad_pkg;

    // ==========================================
    // Register map (byte addresses)
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_OPA = 6'h04;
    localparam logic [5:0] OFS_OPB = 6'h08;
    localparam logic [5:0] OFS_ACC0L = 6'h0c;
    localparam logic [5:0] OFS_ACC0H = 6'h10;
    localparam logic [5:0] OFS_ACC1L = 6'h14;
    localparam logic [5:0] OFS_ACC1H = 6'h18;
    localparam logic [5:0] OFS_RESULT = 6'h1c;
    localparam logic [5:0] OFS_FLAGS = 6'h20;
    localparam logic [5:0] OFS_STATUS = 6'h24;

    // ==========================================
    // Command word fields
    localparam int CTL_SAT = 4;
    localparam int CTL_ENC32 = 5;
    localparam int CTL_DSTHI = 6;
    localparam int CTL_AHI = 7;
    localparam int CTL_BHI = 8;
    localparam int CTL_SRC1 = 9;
    localparam int CTL_DST0 = 10;
    localparam int CTL_DST1 = 11;
    localparam int CTL_STEP4 = 12;
    localparam int CTL_IMM_LSB = 16;
    localparam int IMM_W = 7;
    localparam int ACC_W = 40;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ABS_D = 4'h1,
        OP_ABS_ACC = 4'h2,
        OP_ADD_P = 4'h3,
        OP_ADD_D = 4'h4,
        OP_ADD_H = 4'h5,
        OP_IMM_D = 4'h6,
        OP_IMM_P = 4'h7,
        OP_IMM_I = 4'h8,
        OP_DIV_INIT = 4'h9,
        OP_DIV_ITER = 4'ha
    } aad_op_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } aad_bus_t;

    // Bit 0 upward: zero, sign, carry, data wrap, its sticky, acc0 pair, acc1 pair, qsign
    typedef struct packed {
        logic quotientSign;
        logic acc1WrapSticky;
        logic acc1WrapFlag;
        logic acc0WrapSticky;
        logic acc0WrapFlag;
        logic dataWrapSticky;
        logic dataWrap;
        logic carryFlag;
        logic signFlag;
        logic zeroFlag;
    } aad_flags_t;

    localparam aad_flags_t FLAGS_RST = '0;
    localparam logic [31:0] WORD_MIN = 32'h8000_0000;
    localparam logic [31:0] WORD_MAX = 32'h7fff_ffff;
    localparam logic [39:0] ACC_MIN = 40'h80_0000_0000;
    localparam logic [39:0] ACC_MAX = 40'h7f_ffff_ffff;
    localparam logic [31:0] IDX_STEP_HALF = 32'h0000_0002;
    localparam logic [31:0] IDX_STEP_WORD = 32'h0000_0004;

endpackage : aad_pkg

/* File: aad_adder.sv */
`timescale 1ns/1ps
module aad_adder #(
    parameter int W = 32
) (
    input wire logic [W-1:0] opA,
    input wire logic [W-1:0] opB,
    input wire logic sat,
    output logic [W-1:0] sum,
    output logic zero,
    output logic sign,
    output logic carry,
    output logic ovf
);
    import aad_pkg::*;

    logic [W:0] raw;

    initial begin
        if (W < 2) $error("aad_adder width too small");
    end

    // ==========================================
    // Add with optional clamp on signed overflow
    always_comb begin
        raw = {1'b0, opA} + {1'b0, opB};
        carry = raw[W];
        ovf = (opA[W-1] == opB[W-1]) && (raw[W-1] != opA[W-1]);
        if (sat && ovf) begin
            sum = opA[W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
        end else begin
            sum = raw[W-1:0];
        end
        zero = (sum == '0);
        sign = sum[W-1];
    end
endmodule : aad_adder

/* File: aad_divider.sv */
`timescale 1ns/1ps
module aad_divider (
    input wire logic [31:0] dividend,
    input wire logic [15:0] divisor,
    input wire logic qsIn,
    input wire logic initStep,
    output logic [31:0] newDividend,
    output logic qsOut
);
    import aad_pkg::*;

    logic [15:0] upper;
    logic [31:0] mid;

    // ==========================================
    // One non-restoring step
    always_comb begin
        upper = qsIn ? dividend[31:16] + divisor : dividend[31:16] - divisor;
        mid = initStep ? dividend : {upper, dividend[15:0]};
        qsOut = mid[31] ^ divisor[15];
        // Shift without carry; init inserts qsign, iterate its inverse
        newDividend = {mid[30:0], initStep ? qsOut : ~qsOut};
    end
endmodule : aad_divider

/* File: aad_bus_model.sv */
`timescale 1ns/1ps
module aad_bus_model (
    input wire logic core_clk,
    output logic [5:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    // ==========================================
    // Avalon master, one request at a time
    initial begin
        address = 6'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
    end

    // Holds everything until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        @(posedge core_clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= ~w;
        write <= w;
        @(posedge core_clk);
        while (waitrequest !== 1'b0) @(posedge core_clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // Released data lines must not keep the last value
        writedata <= ~d;
        #1;
    endtask : xfer
endmodule : aad_bus_model

/* File: tb_abs_add_divide_alu.sv */
`timescale 1ns/1ps
module tb_abs_add_divide_alu;
    import aad_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    aad_flags_t statusFlags;
    int failures = 0;
    int checks = 0;
    localparam logic [31:0] SAT = 32'h1 << CTL_SAT;
    localparam logic [31:0] E32 = 32'h1 << CTL_ENC32;
    localparam logic [31:0] BHI = 32'h1 << CTL_BHI;
    localparam logic [31:0] DHI = 32'h1 << CTL_DSTHI;
    localparam logic [31:0] DST2 = (32'h1 << CTL_DST0) | (32'h1 << CTL_DST1);

    always #4 core_clk = ~core_clk;

    aad_bus_model host (.core_clk(core_clk), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest));
    aad_alu dut (.core_clk(core_clk), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .statusFlags(statusFlags));

    // ==========================================
    // Helpers
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic chkf(logic [9:0] e);
        chk("flags", {22'h0, e}, {22'h0, statusFlags});
    endtask : chkf
    task automatic wr(logic [5:0] a, logic [31:0] d, logic [3:0] be = 4'hf);
        logic [31:0] q;
        host.xfer(1'b1, a, d, be, q);
    endtask : wr
    task automatic rd(logic [5:0] a, output logic [31:0] q);
        host.xfer(1'b0, a, 32'h0, 4'hf, q);
    endtask : rd
    task automatic rdc(string n, logic [5:0] a, logic [31:0] e);
        logic [31:0] q;
        rd(a, q);
        chk(n, e, q);
    endtask : rdc
    function automatic logic [31:0] ctl(aad_op_t op, logic [31:0] b);
        return {28'h0, op} | b;
    endfunction : ctl
    // Command runs on the CTRL write, with operands as they stand
    task automatic run(logic [31:0] a, logic [31:0] b, logic [31:0] c);
        wr(OFS_OPA, a);
        wr(OFS_OPB, b);
        wr(OFS_CTRL, c);
    endtask : run

    // ==========================================
    // Scenarios
    task automatic t_reset();
        chkf(10'h000);
        rdc("result", OFS_RESULT, 32'h0);
        rdc("unmapped", 6'h28, 32'h0);
        wr(OFS_OPA, 32'hffff_ffff);
        wr(OFS_OPA, 32'h0, 4'h1);
        rdc("opa lanes", OFS_OPA, 32'hffff_ff00);
    endtask : t_reset
    task automatic t_abs();
        run(32'hffff_fffb, 32'h0, ctl(OP_ABS_D, 32'h0));
        rdc("abs", OFS_RESULT, 32'h5);
        chkf(10'h000);
        run(WORD_MIN, 32'h0, ctl(OP_ABS_D, 32'h0));
        rdc("abs min", OFS_RESULT, WORD_MAX);
        chkf(10'h018);
        run(32'h0, 32'h0, ctl(OP_ABS_D, 32'h0));
        rdc("abs zero", OFS_RESULT, 32'h0);
        chkf(10'h011);
    endtask : t_abs
    task automatic t_add();
        wr(OFS_FLAGS, 32'h0);
        run(WORD_MAX, 32'h1, ctl(OP_ADD_D, E32 | SAT));
        rdc("add sat", OFS_RESULT, WORD_MAX);
        chkf(10'h018);
        rdc("pair long", OFS_STATUS, 32'h1);
        run(WORD_MAX, 32'h1, ctl(OP_ADD_D, E32));
        rdc("add wrap", OFS_RESULT, WORD_MIN);
        chkf(10'h01a);
        run(WORD_MAX, 32'h1, ctl(OP_ADD_D, SAT));
        rdc("add short", OFS_RESULT, WORD_MIN);
        rdc("pair short", OFS_STATUS, 32'h0);
        run(32'hffff_ffff, 32'h1, ctl(OP_ADD_D, E32));
        chkf(10'h015);
    endtask : t_add
    task automatic t_ptr();
        wr(OFS_FLAGS, 32'h2a5);
        run(32'h100, 32'h20, ctl(OP_ADD_P, 32'h0));
        rdc("ptr add", OFS_RESULT, 32'h120);
        chkf(10'h2a5);
        run(32'h1000, 32'h0, ctl(OP_IMM_P, 32'h7c << CTL_IMM_LSB));
        rdc("imm ptr", OFS_RESULT, 32'hffc);
        chkf(10'h2a5);
        rdc("pair ptr", OFS_STATUS, 32'h0);
        run(32'h10, 32'h0, ctl(OP_IMM_I, 32'h1 << CTL_STEP4));
        rdc("idx 4", OFS_RESULT, 32'h14);
        rdc("pair idx", OFS_STATUS, 32'h1);
        run(32'h10, 32'h0, ctl(OP_IMM_I, 32'h0));
        rdc("idx 2", OFS_RESULT, 32'h12);
        chkf(10'h2a5);
    endtask : t_ptr
    task automatic t_imm();
        wr(OFS_FLAGS, 32'h0);
        run(32'h40, 32'h0, ctl(OP_IMM_D, 32'h40 << CTL_IMM_LSB));
        rdc("imm -64", OFS_RESULT, 32'h0);
        chkf(10'h005);
        run(WORD_MAX, 32'h0, ctl(OP_IMM_D, 32'h3f << CTL_IMM_LSB));
        rdc("imm 63", OFS_RESULT, 32'h8000_003e);
        chkf(10'h01a);
    endtask : t_imm
    task automatic t_half();
        logic [31:0] q;
        run(32'h7000, 32'h2000_0000, ctl(OP_ADD_H, E32 | BHI));
        rdc("half lo", OFS_RESULT, 32'h8000_9000);
        run(32'h7000, 32'h2000_0000, ctl(OP_ADD_H, E32 | BHI | DHI));
        rdc("half hi", OFS_RESULT, 32'h9000_9000);
        run(32'h1, 32'h1, ctl(OP_ADD_H, 32'h0));
        rdc("half short", OFS_RESULT, 32'h9000_9000);
        rd(OFS_STATUS, q);
        chk("refused", 32'h2, q & 32'h2);
    endtask : t_half
    task automatic t_div();
        logic [31:0] a;
        logic [15:0] d;
        logic q;
        a = 32'h8123_4567;
        d = 16'h0005;
        q = 1'b0;
        // Divisor upper half is junk on purpose
        wr(OFS_OPA, a);
        wr(OFS_OPB, 32'hffff_0005);
        for (int i = 0; i < 4; i++) begin
            if (i == 0) begin
                q = a[31] ^ d[15];
                a = {a[30:0], q};
            end else begin
                a[31:16] = q ? a[31:16] + d : a[31:16] - d;
                q = a[31] ^ d[15];
                a = {a[30:0], ~q};
            end
            wr(OFS_CTRL, ctl(i == 0 ? OP_DIV_INIT : OP_DIV_ITER, 32'h0));
            chk("qsign", {31'h0, q}, {31'h0, statusFlags.quotientSign});
            rdc("dividend", OFS_OPA, a);
        end
        rdc("divisor", OFS_OPB, 32'hffff_0005);
    endtask : t_div
    task automatic t_acc();
        wr(OFS_FLAGS, 32'h0);
        wr(OFS_ACC0L, 32'h0);
        wr(OFS_ACC0H, 32'h0);
        wr(OFS_ACC1L, 32'hffff_fffb);
        wr(OFS_ACC1H, 32'hff);
        wr(OFS_CTRL, ctl(OP_ABS_ACC, DST2));
        rdc("acc1 lo", OFS_ACC1L, 32'h5);
        rdc("acc1 hi", OFS_ACC1H, 32'h0);
        chkf(10'h001);
        wr(OFS_CTRL, ctl(OP_ABS_ACC, (32'h1 << CTL_SRC1) | (32'h1 << CTL_DST0)));
        rdc("acc0 cross", OFS_ACC0L, 32'h5);
        chkf(10'h000);
    endtask : t_acc

    // ==========================================
    // Verdict
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1;
        t_reset();
        t_abs();
        t_add();
        t_ptr();
        t_imm();
        t_half();
        t_div();
        t_acc();
        report_and_stop();
    end
endmodule : tb_abs_add_divide_alu
